// ---- verilog/wave_consts.svh ----
// Offsets, field positions and reset values of the waveform unit
`ifndef WAVE_CONSTS_SVH
`define WAVE_CONSTS_SVH
`define OFS_CONTROL    8'h00
`define OFS_POLARITY   8'h04
`define OFS_CLKSEL     8'h08
`define OFS_RISE_DB    8'h0c
`define OFS_FALL_DB    8'h10
`define OFS_SD_CTRL    8'h14
`define OFS_SD_SRC     8'h18
`define OFS_FLAG       8'h1c
`define BIT_EN         7
`define BIT_LOAD       6
`define BIT_SHUTDOWN   7
`define BIT_REN        6
`define BIT_INPUT      5
`define RST_SHUTDOWN   1'b1
`define RST_DB         6'h00
`define AHB_NONSEQ     2'h2
`endif

// ---- verilog/wave_pkg.sv ----
// Types shared by the waveform unit
package wave_pkg;
  typedef enum logic [2:0] {
    MODE_ASYNC_STEER = 3'b000,
    MODE_SYNC_STEER  = 3'b001,
    MODE_FWD_FULL    = 3'b010,
    MODE_REV_FULL    = 3'b011,
    MODE_HALF        = 3'b100,
    MODE_PUSH_PULL   = 3'b101
  } mode_e;
  typedef struct packed {
    logic       shutdown;
    logic       ren;
    logic [1:0] override_level_pair_two;
    logic [1:0] override_level_pair_one;
  } sd_ctrl_s;
endpackage : wave_pkg

// ---- verilog/waveform_deadband_shutdown.sv ----
// Dead band, auto-shutdown and restart of the complementary waveform unit
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "wave_consts.svh"
module waveform_deadband_shutdown #(
  parameter int NSRC = 7
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              data_in,
  input  wire logic [NSRC-1:0]   shutdown_in_n,
  output logic                   first_output,
  output logic                   second_output,
  output logic                   third_output,
  output logic                   fourth_output,
  output logic                   shutdown_event_flag,
  output logic                   osc_keep_on
);
  logic                 en;
  logic                 buffer_load_request;
  wave_pkg::mode_e      mode;
  logic [3:0]           pol;
  logic                 clk_sel;
  logic [5:0]           rise_shadow;
  logic [5:0]           fall_shadow;
  logic [5:0]           rising_deadband_count;
  logic [5:0]           falling_deadband_count;
  wave_pkg::sd_ctrl_s   sd;
  logic [NSRC-1:0]      shutdown_source_on;
  logic                 load_armed;
  logic [NSRC-1:0]      sd_meta;
  logic [NSRC-1:0]      sd_sync;
  logic                 in_meta;
  logic                 in_sync;
  logic                 in_prev;
  logic                 in_rise;
  logic                 in_fall;
  logic                 sd_hw;
  logic [5:0]           rise_cnt;
  logic [5:0]           fall_cnt;
  logic                 dir_fwd;
  logic                 running;
  logic                 wr_pend;
  logic [7:0]           wr_addr;
  logic                 wr_go;
  logic [7:0]           wd;
  logic [3:0]           raw;

  // Bus answers at once; every transfer is single cycle and OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase captured for the following write data phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && hwrite && htrans == `AHB_NONSEQ;
      wr_addr <= haddr;
    end
  end
  assign wr_go = wr_pend;
  assign wd    = hwdata[7:0];

  // Two flops on every pin before logic looks at it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_meta <= '1;
      sd_sync <= '1;
      in_meta <= 1'b0;
      in_sync <= 1'b0;
      in_prev <= 1'b0;
    end else begin
      sd_meta <= shutdown_in_n;
      sd_sync <= sd_meta;
      in_meta <= data_in;
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end
  assign in_rise = in_sync & ~in_prev;
  assign in_fall = ~in_sync & in_prev;
  // Sources are active low; disabled ones never count
  assign sd_hw = |(shutdown_source_on & ~sd_sync);

  // Plain configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en                 <= 1'b0;
      mode               <= wave_pkg::MODE_ASYNC_STEER;
      pol                <= 4'h0;
      clk_sel            <= 1'b0;
      rise_shadow        <= `RST_DB;
      fall_shadow        <= `RST_DB;
      shutdown_source_on <= '0;
      sd.ren             <= 1'b0;
      sd.override_level_pair_two <= 2'h0;
      sd.override_level_pair_one <= 2'h0;
    end else if (wr_go) begin
      unique case (wr_addr)
        `OFS_CONTROL: begin
          en   <= wd[`BIT_EN];
          mode <= wave_pkg::mode_e'(wd[2:0]);
        end
        `OFS_POLARITY: pol <= wd[3:0];
        `OFS_CLKSEL:   clk_sel <= wd[0];
        `OFS_RISE_DB:  rise_shadow <= wd[5:0];
        `OFS_FALL_DB:  fall_shadow <= wd[5:0];
        `OFS_SD_CTRL: begin
          sd.ren <= wd[`BIT_REN];
          sd.override_level_pair_two <= wd[5:4];
          sd.override_level_pair_one <= wd[3:2];
        end
        `OFS_SD_SRC:   shutdown_source_on <= wd[NSRC-1:0];
        default: ;
      endcase
    end
  end

  // Load request: set only while already enabled, cleared when buffers load
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_load_request <= 1'b0;
      load_armed          <= 1'b0;
    end else begin
      if (!en) begin
        load_armed <= 1'b0;
      end else if (buffer_load_request && in_fall) begin
        load_armed <= 1'b1;
      end else if (load_armed && in_rise) begin
        load_armed <= 1'b0;
      end
      if (wr_go && wr_addr == `OFS_CONTROL && en && wd[`BIT_LOAD]) begin
        buffer_load_request <= 1'b1;
      end else if (load_armed && in_rise) begin
        buffer_load_request <= 1'b0;
      end else if (!en) begin
        buffer_load_request <= 1'b0;
      end
    end
  end

  // Active dead band buffers; a disabled unit follows writes at once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rising_deadband_count  <= `RST_DB;
      falling_deadband_count <= `RST_DB;
    end else if (!en) begin
      rising_deadband_count  <= rise_shadow;
      falling_deadband_count <= fall_shadow;
    end else if (load_armed && in_rise) begin
      rising_deadband_count  <= rise_shadow;
      falling_deadband_count <= fall_shadow;
    end
  end

  // Shutdown bit: hardware set wins over any software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sd.shutdown <= `RST_SHUTDOWN;
    end else if (sd_hw) begin
      sd.shutdown <= 1'b1;
    end else if (wr_go && wr_addr == `OFS_SD_CTRL) begin
      sd.shutdown <= wd[`BIT_SHUTDOWN];
    end else if (sd.ren && in_rise) begin
      sd.shutdown <= 1'b0;
    end
  end

  // Event flag: set on each entry to shutdown, write one to clear, set wins
  logic sd_prev;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_prev             <= `RST_SHUTDOWN;
      shutdown_event_flag <= 1'b0;
    end else begin
      sd_prev <= sd.shutdown;
      if (sd.shutdown && !sd_prev) begin
        shutdown_event_flag <= 1'b1;
      end else if (wr_go && wr_addr == `OFS_FLAG && wd[0]) begin
        shutdown_event_flag <= 1'b0;
      end
    end
  end

  // Output waits for the first input rise after shutdown ends
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
    end else if (sd.shutdown || sd_hw || !en) begin
      running <= 1'b0;
    end else if (in_rise) begin
      running <= 1'b1;
    end
  end

  // Half bridge edge cycle is already the first dead period, so load one less
  function automatic logic [5:0] first_period(input logic [5:0] count);
    return count - 6'(count != 6'h00);
  endfunction : first_period

  // Two down counters, restarted on each input edge in half bridge, on a direction-changing rise in full bridge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt <= 6'h00;
      fall_cnt <= 6'h00;
      dir_fwd  <= 1'b1;
    end else if (mode == wave_pkg::MODE_HALF) begin
      rise_cnt <= in_rise ? first_period(rising_deadband_count) : in_fall ? 6'h00 :
                  rise_cnt - 6'(rise_cnt != 6'h00);
      fall_cnt <= in_fall ? first_period(falling_deadband_count) : in_rise ? 6'h00 :
                  fall_cnt - 6'(fall_cnt != 6'h00);
    end else if (in_rise && (mode == wave_pkg::MODE_FWD_FULL ||
                             mode == wave_pkg::MODE_REV_FULL)) begin
      // Direction latches on a rise; the delay only on a change
      dir_fwd <= ~mode[0];
      rise_cnt <= (dir_fwd && mode[0]) ? rising_deadband_count : 6'h00;
      fall_cnt <= (!dir_fwd && !mode[0]) ? falling_deadband_count : 6'h00;
    end else begin
      rise_cnt <= rise_cnt - 6'(rise_cnt != 6'h00);
      fall_cnt <= fall_cnt - 6'(fall_cnt != 6'h00);
    end
  end

  // Raw active-high levels per mode, before polarity
  always_comb begin
    raw = 4'h0;
    unique case (mode)
      wave_pkg::MODE_HALF: begin
        // The edge cycle looks at the new count, so no stale zero slips a pulse out
        raw[0] = in_sync &&
                 (in_rise ? rising_deadband_count == 6'h00 : rise_cnt == 6'h00);
        raw[1] = !in_sync &&
                 (in_fall ? falling_deadband_count == 6'h00 : fall_cnt == 6'h00);
      end
      wave_pkg::MODE_FWD_FULL, wave_pkg::MODE_REV_FULL: begin
        raw[0] = dir_fwd;
        raw[2] = !dir_fwd;
        raw[3] = dir_fwd && in_sync && fall_cnt == 6'h00;
        raw[1] = !dir_fwd && in_sync && rise_cnt == 6'h00;
      end
      default: raw = 4'h0; // Steering and push-pull live elsewhere
    endcase
  end

  // Overrides bypass polarity; a live source overrides without waiting
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_output  <= 1'b0;
      second_output <= 1'b0;
      third_output  <= 1'b0;
      fourth_output <= 1'b0;
    end else if (!running || sd_hw) begin
      first_output  <= sd.override_level_pair_one[0];
      third_output  <= sd.override_level_pair_one[1];
      second_output <= sd.override_level_pair_two[0];
      fourth_output <= sd.override_level_pair_two[1];
    end else begin
      first_output  <= raw[0] ^ pol[0];
      second_output <= raw[1] ^ pol[1];
      third_output  <= raw[2] ^ pol[2];
      fourth_output <= raw[3] ^ pol[3];
    end
  end

  // Fast oscillator request; the clock itself is supplied from outside
  assign osc_keep_on = en & clk_sel;

  // Read data registered in the address phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && !hwrite && htrans == `AHB_NONSEQ) begin
      unique case (haddr)
        `OFS_CONTROL:  hrdata <= {24'h0, en, buffer_load_request, 3'h0, mode};
        `OFS_POLARITY: hrdata <= {26'h0, in_sync, 1'b0, pol};
        `OFS_CLKSEL:   hrdata <= {31'h0, clk_sel};
        `OFS_RISE_DB:  hrdata <= {26'h0, rise_shadow};
        `OFS_FALL_DB:  hrdata <= {26'h0, fall_shadow};
        `OFS_SD_CTRL:  hrdata <= {24'h0, sd, 2'h0};
        `OFS_SD_SRC:   hrdata <= {{(32-NSRC){1'b0}}, shutdown_source_on};
        `OFS_FLAG:     hrdata <= {31'h0, shutdown_event_flag};
        default:       hrdata <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_hw_sets_sd: assert property (sd_hw |=> sd.shutdown)
    else $error("live source did not set shutdown");
  chk_sw_clear_block: assert property (sd_hw && sd.shutdown |=> sd.shutdown)
    else $error("shutdown cleared with source present");
  chk_override_a: assert property (sd_hw |=> first_output == $past(sd.override_level_pair_one[0]))
    else $error("first output not at override");
  chk_override_d: assert property (sd_hw |=> fourth_output == $past(sd.override_level_pair_two[1]))
    else $error("fourth output not at override");
  chk_event_flag: assert property ($rose(sd.shutdown) |=> shutdown_event_flag)
    else $error("flag not set on shutdown");
  chk_flag_sticky: assert property (shutdown_event_flag && !(wr_go && wr_addr == `OFS_FLAG)
    |=> shutdown_event_flag)
    else $error("flag dropped without a clear");
  chk_half_fall_db: assert property (mode == wave_pkg::MODE_HALF && in_fall &&
    falling_deadband_count == 6'h05 |=> (!second_output || !running) [*5])
    else $error("second output rose inside dead band");
  chk_zero_db: assert property (mode == wave_pkg::MODE_HALF && in_fall && running && !sd_hw &&
    falling_deadband_count == 6'h00 |=> second_output != $past(pol[1]))
    else $error("zero count produced a dead band");
  chk_load_clear: assert property (load_armed && in_rise && en && !wr_go
    |=> !buffer_load_request)
    else $error("load request not cleared");
  chk_restart_rise: assert property ($rose(running) |-> $past(in_rise))
    else $error("restart without input rise");
endmodule : waveform_deadband_shutdown
`default_nettype wire

// ---- dv/bridge_driver_model.sv ----
// Behavioural model of the bridge switch drivers on the far side
`timescale 1ns/1ps
`default_nettype none
module bridge_driver_model #(
  parameter int TRIP_DELAY = 3
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  gate,
  input  wire logic        trip,
  output logic             fault_n,
  output logic [15:0]      overlaps
);
  logic [7:0] trip_age;

  // Fault line answers a commanded trip late, as a slow desaturation sensor would
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_age <= 8'h00;
      overlaps <= 16'h0000;
    end else begin
      trip_age <= (trip && trip_age != 8'hff) ? trip_age + 8'h01 : (trip ? trip_age : 8'h00);
      // Both switches of one leg on together would short the supply
      if ((gate[0] & gate[1]) | (gate[2] & gate[3])) begin
        overlaps <= overlaps + 16'h0001;
      end
    end
  end

  // Fault line has a pull-up, so it sits high when no fault is reported
  assign fault_n = !(trip && int'(trip_age) >= TRIP_DELAY);
endmodule : bridge_driver_model
`default_nettype wire

// ---- dv/test_waveform_deadband_shutdown.sv ----
// Self-checking bench of the dead band and shutdown block
`timescale 1ns/1ps
`default_nettype none
`include "wave_consts.svh"
module test_waveform_deadband_shutdown;
  logic               sys_clk;
  logic               rst_n;
  logic               hwrite;
  logic               data_in;
  logic               trip;
  logic [7:0]         haddr;
  logic [1:0]         htrans;
  logic [31:0]        hwdata;
  logic [31:0]        rd;
  logic [6:0]         src_n;
  logic               hreadyout;
  logic               osc_keep_on;
  logic               flag;
  logic               fault_n;
  logic [31:0]        hrdata;
  wire  [3:0]         outs;
  logic [15:0]        overlaps;
  wave_pkg::sd_ctrl_s sd;
  int                 fails = 0;
  int                 n_compared = 0;
  int                 cycles = 0;
  int                 ta;
  int                 tb;
  int                 cur;
  int                 dbv[4] = '{5, 63, 9, 20};
  logic               dbl[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  // Samples from input change to a visible output: two sync flops, edge, output flop
  localparam int      IN_TO_OUT = 3;

  waveform_deadband_shutdown #(.NSRC(7)) i_waveform_deadband_shutdown (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .data_in(data_in),
    .shutdown_in_n({src_n[6:1], src_n[0] & fault_n}),
    .first_output(outs[0]), .second_output(outs[1]), .third_output(outs[2]),
    .fourth_output(outs[3]), .shutdown_event_flag(flag), .osc_keep_on(osc_keep_on));

  bridge_driver_model i_bridge_driver_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .gate(outs), .trip(trip), .fault_n(fault_n),
    .overlaps(overlaps));

  // Clock of 5 ns
  always #2.5 sys_clk = ~sys_clk;

  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_n(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      fails++;
      $display("unexpected at %0t: cycles %0d, want %0d", $time, got, exp);
    end
  endtask : cmp_n

  // One single AHB transfer; each wait ends on hreadyout and has no limit but the hang guard
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= `AHB_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask : rd_chk

  task automatic wr_sd();
    wr(`OFS_SD_CTRL, {24'h0, sd, 2'b00});
  endtask : wr_sd

  // Drive the input, then note the first cycle each watched output takes its value
  task automatic track(input logic v, input int ia, input logic ea, input int ib,
                       input logic eb);
    data_in <= v;
    ta = -1;
    tb = -1;
    for (int k = 0; k < 90; k++) begin
      @(posedge sys_clk);
      if (ta < 0 && outs[ia] === ea) ta = k;
      if (tb < 0 && outs[ib] === eb) tb = k;
    end
  endtask : track

  // Main sequence; software enables the unit early and reconfigures it while enabled
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    hwrite = 1'b0;
    data_in = 1'b0;
    trip = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwdata = 32'h0;
    src_n = 7'h7f;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    cmp({28'h0, outs}, 32'h0);
    rd_chk(`OFS_SD_CTRL, 32'h80);
    rd_chk(`OFS_FALL_DB, 32'h0);
    wr(8'h20, 32'hff);
    rd_chk(8'h20, 32'h0);
    sd = '{1'b1, 1'b0, 2'b01, 2'b10};
    wr_sd();
    repeat (4) @(posedge sys_clk);
    cmp({28'h0, outs}, 32'h6);
    wr(`OFS_FLAG, 32'h1);
    wr(`OFS_CONTROL, 32'hc4);
    rd_chk(`OFS_CONTROL, 32'h84);
    sd.shutdown = 1'b0;
    wr_sd();
    track(1'b1, 0, 1'b1, 1, 1'b0);
    cmp({28'h0, outs}, 32'h1);
    // Falling dead band sweep; a new value waits for load request, fall and rise
    cur = 0;
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_FALL_DB, dbv[i]);
      if (dbl[i]) wr(`OFS_CONTROL, 32'hc4);
      track(1'b0, 0, 1'b0, 1, 1'b1);
      cmp_n(tb - ta, cur);
      track(1'b1, 0, 1'b1, 1, 1'b0);
      if (dbl[i]) cur = dbv[i];
      rd_chk(`OFS_CONTROL, 32'h84);
    end
    // Low pulse shorter than the dead band of 20
    data_in <= 1'b0;
    repeat (5) @(posedge sys_clk);
    track(1'b1, 1, 1'b1, 1, 1'b1);
    cmp_n(ta, -1);
    wr(`OFS_CONTROL, 32'h83);
    track(1'b0, 0, 1'b0, 0, 1'b0);
    track(1'b1, 0, 1'b0, 0, 1'b0);
    cmp({28'h0, outs}, 32'h6);
    wr(`OFS_CONTROL, 32'h82);
    track(1'b0, 0, 1'b0, 0, 1'b0);
    // Forward delay only on the first rise after the reverse-to-forward change;
    // later the first output is already on, so the fourth is timed from the input
    for (int j = 0; j < 2; j++) begin
      track(1'b1, 0, 1'b1, 3, 1'b1);
      cmp_n((j == 0) ? tb - ta : tb, (j == 0) ? 20 : IN_TO_OUT);
      cmp({28'h0, outs}, 32'h9);
      track(1'b0, 3, 1'b0, 3, 1'b0);
    end
    sd.shutdown = 1'b1;
    wr_sd();
    track(1'b1, 0, 1'b1, 0, 1'b1);
    cmp({27'h0, flag, outs}, 32'h16);
    sd.shutdown = 1'b0;
    wr_sd();
    rd_chk(`OFS_FLAG, 32'h1);
    wr(`OFS_FLAG, 32'h1);
    track(1'b0, 0, 1'b0, 0, 1'b0);
    track(1'b1, 3, 1'b1, 3, 1'b1);
    cmp({27'h0, flag, outs}, 32'h9);
    // Fault from the driver model on the pin source
    wr(`OFS_SD_SRC, 32'h1);
    trip <= 1'b1;
    track(1'b1, 0, 1'b0, 2, 1'b1);
    cmp_n(ta >= 0 && ta < 12, 1);
    rd_chk(`OFS_FLAG, 32'h1);
    wr_sd();
    rd_chk(`OFS_SD_CTRL, 32'h98);
    wr(`OFS_SD_SRC, 32'h0);
    wr_sd();
    rd_chk(`OFS_SD_CTRL, 32'h18);
    trip <= 1'b0;
    sd.ren = 1'b1;
    wr_sd();
    // Each source alone: the others held low must be ignored
    for (int s = 0; s < 7; s++) begin
      wr(`OFS_SD_SRC, 32'h1 << s);
      src_n <= 7'h1 << s;
      track(1'b0, 0, 1'b0, 0, 1'b0);
      rd_chk(`OFS_SD_CTRL, 32'h58);
      src_n <= 7'h0;
      track(1'b1, 0, 1'b0, 0, 1'b0);
      rd_chk(`OFS_SD_CTRL, 32'hd8);
      src_n <= 7'h7f;
      track(1'b0, 0, 1'b0, 0, 1'b0);
      track(1'b1, 0, 1'b0, 0, 1'b0);
      rd_chk(`OFS_SD_CTRL, 32'h58);
    end
    wr(`OFS_CLKSEL, 32'h1);
    @(posedge sys_clk);
    cmp({31'h0, osc_keep_on}, 32'h1);
    wr(`OFS_CONTROL, 32'h02);
    @(posedge sys_clk);
    cmp({31'h0, osc_keep_on}, 32'h0);
    cmp({16'h0, overlaps}, 32'h0);
    close_out();
  end
endmodule : test_waveform_deadband_shutdown
`default_nettype wire
